// ===== shared/desc_decode_regs.svh
// offsets, field positions, reset values and limits for the descriptor field decoder
`ifndef DESC_DECODE_REGS_SVH
`define DESC_DECODE_REGS_SVH

// register port offsets (byte addresses, one 32-bit word each)
`define REG_CTRL          8'h00
`define REG_MAX_XFER      8'h04
`define REG_MAX_BATCH     8'h08
`define REG_FP_CONV       8'h0c
`define REG_STATUS        8'h10
`define REG_ERR_CODE      8'h14
`define REG_SW_ERROR      8'h18
`define REG_DESC_COUNT    8'h1c
`define REG_ADDR_W        8

// descriptor byte offsets, expressed as 32-bit word index into the 64-byte descriptor
`define DESC_WORDS        16
`define OFS_COMPL_LO      4'h2
`define OFS_COMPL_HI      4'h3
`define OFS_SRC_LO        4'h4
`define OFS_SRC_HI        4'h5
`define OFS_DST_LO        4'h6
`define OFS_DST_HI        4'h7
`define OFS_SIZE          4'h8
`define OFS_INTH          4'h9
`define OFS_ELEM40        4'ha
`define OFS_TYPES         4'he

// flag bit positions inside descriptor word 1 (flags field)
`define FLG_COMPL_VALID   2
`define FLG_REQ_RECORD    3
`define FLG_REQ_INTR      4

// reset values and capability maxima
`define RST_MAX_XFER      32'h0000_1000
`define RST_MAX_BATCH     32'h0000_0020
`define RST_FP_CONV       32'h0000_0000
`define CAP_MAX_XFER      32'h8000_0000
`define CAP_MAX_BATCH     32'h0000_0400

// data type and compute codes
`define DT_LAST_VALID     4'h9
`define DT_FIRST_FLOAT    4'h4
`define CT_ADD            4'h1
`define CT_AND            4'h3
`define CT_OR             4'h4
`define CT_XOR            4'h5
`define CT_MIN            4'h6
`define CT_MAX            4'h7

`endif

// ===== shared/desc_decode_pkg.sv
// types shared by the descriptor field decoder
package desc_decode_pkg;

  // operation class, picked by the submitter's opcode input
  typedef enum logic [2:0] {
    OP_PLAIN    = 3'h0,   // memory move style, transfer size in bytes
    OP_BATCH    = 3'h1,   // size field holds descriptor count
    OP_TYPED32  = 3'h2,   // type conversion, element count at 32
    OP_REDUCE   = 3'h3,   // reduce family, count at 32, compute type used
    OP_GATHER40 = 3'h4,   // gather/scatter, count at 40
    OP_TWO_SRC  = 3'h5    // destination field is a second source
  } op_class_t;

  // error codes reported at completion
  typedef enum logic [3:0] {
    ERR_NONE       = 4'h0,
    ERR_ZERO_SIZE  = 4'h1,
    ERR_OVER_LIMIT = 4'h2,
    ERR_BATCH_CNT  = 4'h3,
    ERR_DTYPE      = 4'h4,
    ERR_CTYPE      = 4'h5,
    ERR_TYPE_MIX   = 4'h6
  } err_code_t;

endpackage

// ===== hw/desc_field_decode.sv
// descriptor common field decoder with register port
//
// Functional notes
// - completion address from 64-bit field, offset 8
// - completion address ignored when valid flag clear
// - record always if requested, else only errors
// - no record address: error goes to register
// - source at 16, destination at 24, unaligned
// - over-read source chunks, discard the excess
// - destination may act as second source
// - transfer size at 32, queue limit capped
// - interrupt handle at 36, ignored without flag
// - element count at 32 or 40
// - input type bits 3:0, output 7:4, byte 56
// - type codes zero to nine, rest reserved
// - signed integers two's complement via flag
// - compute type from byte 57 bits 3:0
// - compute codes decoded, logic ops integer only
`timescale 1ns/1ps
`default_nettype none
`include "desc_decode_regs.svh"

module desc_field_decode
(
  input  wire logic        ref_clk_i,      // 20 MHz clock
  input  wire logic        srst_i,         // synchronous reset, active high
  input  wire logic        clk_en_i,       // freezes all state while low
  input  wire logic        desc_valid_i,   // one descriptor word offered
  input  wire logic [3:0]  desc_word_i,    // word index within descriptor
  input  wire logic [31:0] desc_data_i,    // descriptor word data
  input  wire logic        desc_last_i,    // last word, start decode
  input  wire logic [2:0]  desc_op_i,      // operation class, with last
  input  wire logic        signed_flag_i,  // signed operand flag, with last
  input  wire logic [7:0]  reg_addr_i,     // register byte address
  input  wire logic [31:0] reg_wdata_i,    // register write data
  input  wire logic        reg_wr_i,       // register write strobe
  input  wire logic        reg_rd_i,       // register read strobe
  output logic      [31:0] reg_rdata_o,    // read data, cycle after strobe
  output logic             done_o,         // decode complete pulse
  output logic      [3:0]  err_code_o,     // error code with done
  output logic             write_record_o, // completion record to be written
  output logic      [63:0] record_addr_o,  // completion record address
  output logic      [63:0] src_addr_o,     // source address
  output logic      [63:0] dst_addr_o,     // destination or second source
  output logic             dst_is_src2_o,  // destination used as second source
  output logic      [31:0] fetch_bytes_o,  // source bytes to fetch, 32-byte rounded
  output logic      [31:0] xfer_bytes_o,   // bytes actually kept
  output logic             intr_req_o,     // completion interrupt wanted
  output logic      [15:0] intr_handle_o,  // interrupt table entry
  output logic      [3:0]  in_type_o,      // input element type
  output logic      [3:0]  out_type_o,     // output element type
  output logic      [3:0]  compute_o,      // compute type
  output logic             signed_o        // integers treated as signed
);

  // ************************************************************
  // descriptor capture
  // ************************************************************

  logic [31:0] desc_r [`DESC_WORDS];   // captured descriptor words
  logic        go_r;                   // decode requested next cycle
  desc_decode_pkg::op_class_t op_r;    // class latched with last word
  logic        sgn_r;                  // signed flag latched with last word

  // store words as they arrive; any word order is accepted
  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i && desc_valid_i)
    begin
      desc_r[desc_word_i] <= desc_data_i;
    end
  end

  // latch operation class and raise decode request
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      go_r  <= 1'b0;
      op_r  <= desc_decode_pkg::OP_PLAIN;
      sgn_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      go_r <= desc_valid_i && desc_last_i;
      if (desc_valid_i && desc_last_i)
      begin
        op_r  <= desc_decode_pkg::op_class_t'(desc_op_i);
        sgn_r <= signed_flag_i;
      end
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************

  logic [31:0] max_xfer_r;    // queue maximum transfer size
  logic [31:0] max_batch_r;   // queue maximum batch size
  logic [31:0] fp_conv_r;     // supported float conversions, bit {in[1:0],out[1:0]}
  logic        enable_r;      // decoder enable
  logic [31:0] sw_error_r;    // software error register
  logic [31:0] count_r;       // descriptors decoded

  // capped limits: queue value never above the capability maximum
  function automatic logic [31:0] cap(input logic [31:0] v, input logic [31:0] c);
    cap = (v > c) ? c : v;
  endfunction

  // element size in bytes from a type code
  function automatic logic [3:0] elem_size(input logic [3:0] t);
    case (t)
      4'h0, 4'h4, 4'h5: elem_size = 4'h1;
      4'h1, 4'h6, 4'h7: elem_size = 4'h2;
      4'h2, 4'h8:       elem_size = 4'h4;
      4'h3, 4'h9:       elem_size = 4'h8;
      default:          elem_size = 4'h0;
    endcase
  endfunction

  // float type check (codes 4 and up, reserved 10..15 included)
  function automatic logic is_float(input logic [3:0] t);
    is_float = (t >= `DT_FIRST_FLOAT);
  endfunction

  // ************************************************************
  // field decode and legality
  // ************************************************************

  logic [63:0] compl_addr;     // completion address field
  logic [7:0]  flags;          // low flag byte
  logic [3:0]  in_t;           // input type field
  logic [3:0]  out_t;          // output type field
  logic [3:0]  ct;             // compute type field
  logic [31:0] size_f;         // size field at offset 32
  logic [31:0] count;          // element or descriptor count
  logic        typed;          // class uses element types
  logic [35:0] bytes_in;       // count times input element size
  logic [35:0] bytes_out;      // count times output element size
  logic        conv_ok;        // float conversion supported
  desc_decode_pkg::err_code_t err_nxt;

  always_comb
  begin
    compl_addr = {desc_r[`OFS_COMPL_HI], desc_r[`OFS_COMPL_LO]};
    flags      = desc_r[1][7:0];
    size_f     = desc_r[`OFS_SIZE];
    in_t       = desc_r[`OFS_TYPES][3:0];
    out_t      = desc_r[`OFS_TYPES][7:4];
    ct         = desc_r[`OFS_TYPES][11:8];
    // gather/scatter count sits at 40, typed ops at 32
    count = (op_r == desc_decode_pkg::OP_GATHER40) ? desc_r[`OFS_ELEM40] : size_f;
    typed = (op_r == desc_decode_pkg::OP_TYPED32) || (op_r == desc_decode_pkg::OP_REDUCE)
         || (op_r == desc_decode_pkg::OP_GATHER40);
    bytes_in  = {4'h0, count} * {32'h0, elem_size(in_t)};
    bytes_out = {4'h0, count} * {32'h0, elem_size(out_t)};
    conv_ok   = fp_conv_r[{1'b0, in_t[1:0], out_t[1:0]}];
    err_nxt   = desc_decode_pkg::ERR_NONE;
    // checks in priority order: zero count, batch or transfer limit, then types, then byte limit, then compute
    if (count == 32'h0)
    begin
      err_nxt = desc_decode_pkg::ERR_ZERO_SIZE;
    end
    else if (op_r == desc_decode_pkg::OP_BATCH)
    begin
      if (count == 32'h1 || count > cap(max_batch_r, `CAP_MAX_BATCH))
      begin
        err_nxt = desc_decode_pkg::ERR_BATCH_CNT;
      end
    end
    else if (!typed)
    begin
      if (count > cap(max_xfer_r, `CAP_MAX_XFER))
      begin
        err_nxt = desc_decode_pkg::ERR_OVER_LIMIT;
      end
    end
    else if (in_t > `DT_LAST_VALID ||
             (op_r != desc_decode_pkg::OP_GATHER40 && out_t > `DT_LAST_VALID))
    begin
      err_nxt = desc_decode_pkg::ERR_DTYPE;
    end
    else if (op_r != desc_decode_pkg::OP_GATHER40 && in_t != out_t &&
             (is_float(in_t) != is_float(out_t) || (is_float(in_t) && !conv_ok)))
    begin
      err_nxt = desc_decode_pkg::ERR_TYPE_MIX;
    end
    else if (bytes_in > {4'h0, cap(max_xfer_r, `CAP_MAX_XFER)} ||
             (op_r != desc_decode_pkg::OP_GATHER40 &&
              bytes_out > {4'h0, cap(max_xfer_r, `CAP_MAX_XFER)}))
    begin
      err_nxt = desc_decode_pkg::ERR_OVER_LIMIT;
    end
    else if (op_r == desc_decode_pkg::OP_REDUCE)
    begin
      case (ct)
        `CT_ADD, `CT_MIN, `CT_MAX:
          err_nxt = desc_decode_pkg::ERR_NONE;
        `CT_AND, `CT_OR, `CT_XOR:
          err_nxt = (is_float(in_t) || is_float(out_t)) ? desc_decode_pkg::ERR_CTYPE
                                                        : desc_decode_pkg::ERR_NONE;
        default:
          err_nxt = desc_decode_pkg::ERR_CTYPE;
      endcase
    end
  end

  // ************************************************************
  // register port
  // ************************************************************

  // register writes
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      enable_r    <= 1'b1;
      max_xfer_r  <= `RST_MAX_XFER;
      max_batch_r <= `RST_MAX_BATCH;
      fp_conv_r   <= `RST_FP_CONV;
    end
    else if (clk_en_i && reg_wr_i)
    begin
      case (reg_addr_i)
        `REG_CTRL:      enable_r    <= reg_wdata_i[0];
        `REG_MAX_XFER:  max_xfer_r  <= reg_wdata_i;
        `REG_MAX_BATCH: max_batch_r <= reg_wdata_i;
        `REG_FP_CONV:   fp_conv_r   <= reg_wdata_i;
        default:        ;   // unmapped writes are dropped
      endcase
    end
  end

  // software error register: hardware set wins over write-one-to-clear
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      sw_error_r <= 32'h0;
    end
    else if (clk_en_i)
    begin
      if (go_r && enable_r && err_nxt != desc_decode_pkg::ERR_NONE && !flags[`FLG_COMPL_VALID])
      begin
        sw_error_r <= {16'h0, 8'h01, 4'h0, err_nxt};
      end
      else if (reg_wr_i && reg_addr_i == `REG_SW_ERROR && reg_wdata_i[8])
      begin
        sw_error_r <= 32'h0;
      end
    end
  end

  // read data, registered, valid the cycle after the strobe only
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o <= 32'h0;
    end
    else if (clk_en_i)
    begin
      reg_rdata_o <= 32'h0;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `REG_CTRL:       reg_rdata_o <= {31'h0, enable_r};
          `REG_MAX_XFER:   reg_rdata_o <= max_xfer_r;
          `REG_MAX_BATCH:  reg_rdata_o <= max_batch_r;
          `REG_FP_CONV:    reg_rdata_o <= fp_conv_r;
          `REG_STATUS:     reg_rdata_o <= {30'h0, write_record_o, done_o};
          `REG_ERR_CODE:   reg_rdata_o <= {28'h0, err_code_o};
          `REG_SW_ERROR:   reg_rdata_o <= sw_error_r;
          `REG_DESC_COUNT: reg_rdata_o <= count_r;
          default:         reg_rdata_o <= 32'h0;   // unmapped reads zero
        endcase
      end
    end
  end

  // ************************************************************
  // results
  // ************************************************************

  // decoded outputs, updated two cycles after the last word
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      done_o         <= 1'b0;
      err_code_o     <= 4'h0;
      write_record_o <= 1'b0;
      record_addr_o  <= 64'h0;
      src_addr_o     <= 64'h0;
      dst_addr_o     <= 64'h0;
      dst_is_src2_o  <= 1'b0;
      fetch_bytes_o  <= 32'h0;
      xfer_bytes_o   <= 32'h0;
      intr_req_o     <= 1'b0;
      intr_handle_o  <= 16'h0;
      in_type_o      <= 4'h0;
      out_type_o     <= 4'h0;
      compute_o      <= 4'h0;
      signed_o       <= 1'b0;
      count_r        <= 32'h0;
    end
    else if (clk_en_i)
    begin
      done_o <= go_r && enable_r;
      if (go_r && enable_r)
      begin
        count_r    <= count_r + 32'h1;
        err_code_o <= err_nxt;
        // record on request, or on error, only with a valid address
        write_record_o <= flags[`FLG_COMPL_VALID] &&
                          (flags[`FLG_REQ_RECORD] || err_nxt != desc_decode_pkg::ERR_NONE);
        record_addr_o  <= flags[`FLG_COMPL_VALID] ? compl_addr : 64'h0;
        src_addr_o     <= {desc_r[`OFS_SRC_HI], desc_r[`OFS_SRC_LO]};
        dst_addr_o     <= {desc_r[`OFS_DST_HI], desc_r[`OFS_DST_LO]};
        dst_is_src2_o  <= (op_r == desc_decode_pkg::OP_TWO_SRC);
        // fetch whole aligned 32-byte chunks; the tail beyond xfer is discarded
        fetch_bytes_o  <= ((desc_r[`OFS_SRC_LO] & 32'h1f) + size_f + 32'h1f) & ~32'h1f;
        xfer_bytes_o   <= typed ? bytes_in[31:0] : size_f;
        intr_req_o     <= flags[`FLG_REQ_INTR];
        intr_handle_o  <= flags[`FLG_REQ_INTR] ? desc_r[`OFS_INTH][15:0] : 16'h0;
        in_type_o      <= in_t;
        out_type_o     <= out_t;
        compute_o      <= (op_r == desc_decode_pkg::OP_REDUCE) ? ct : 4'h0;
        signed_o       <= sgn_r && !is_float(in_t);
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/desc_field_decode_chk.sv
// port assertions for the descriptor field decoder
`timescale 1ns/1ps
`default_nettype none

module desc_field_decode_chk
(
  input  wire logic        ref_clk_i,      // clock
  input  wire logic        srst_i,         // reset
  input  wire logic        clk_en_i,       // run enable
  input  wire logic        desc_valid_i,   // word strobe
  input  wire logic [3:0]  desc_word_i,    // word index
  input  wire logic [31:0] desc_data_i,    // word data
  input  wire logic        desc_last_i,    // last word
  input  wire logic [2:0]  desc_op_i,      // class
  input  wire logic [7:0]  reg_addr_i,     // reg address
  input  wire logic        reg_rd_i,       // read strobe
  input  wire logic [31:0] reg_rdata_o,    // read data
  input  wire logic        done_o,         // done pulse
  input  wire logic [3:0]  err_code_o,     // error code
  input  wire logic        write_record_o, // record wanted
  input  wire logic [63:0] record_addr_o,  // record address
  input  wire logic        dst_is_src2_o,  // second source
  input  wire logic [31:0] fetch_bytes_o,  // fetch size
  input  wire logic [3:0]  compute_o       // compute type
);
  // ****************************************
  // shadow of the descriptor
  // ****************************************
  logic [31:0] w_r [16]; // words as they arrive
  logic [31:0] s_r [16]; // words of the descriptor being finished
  logic [2:0]  op_r;     // its class
  logic        l1_r;     // last word one cycle ago
  logic        l2_r;     // last word two cycles ago
  logic        ok;       // no error reported

  assign ok = (err_code_o == 4'h0);

  // snapshot a cycle after the last word, so early words of the next one cannot spoil it
  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i && desc_valid_i)
      w_r[desc_word_i] <= desc_data_i;
    if (clk_en_i && desc_valid_i && desc_last_i)
      op_r <= desc_op_i;
    if (clk_en_i && l1_r)
      s_r <= w_r;
  end

  // delay line of the last-word event
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      l1_r <= 1'b0;
      l2_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      l1_r <= desc_valid_i && desc_last_i;
      l2_r <= l1_r;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_rd_far;
    clk_en_i && reg_rd_i && reg_addr_i > 8'h1f;
  endsequence

  AST_DONE_LAT: assert property (done_o |-> l2_r)
    else $error("done without descriptor");
  AST_REC_ADDR: assert property (done_o && write_record_o |-> record_addr_o == {s_r[3], s_r[2]})
    else $error("record address wrong");
  AST_REC_RULE: assert property (done_o |-> write_record_o == (s_r[1][2] && (s_r[1][3] || !ok)))
    else $error("record policy wrong");
  AST_SRC2: assert property (done_o |-> dst_is_src2_o == (op_r == 3'h5))
    else $error("second source flag wrong");
  AST_FETCH: assert property (done_o && ok && op_r == 3'h0 |->
    fetch_bytes_o == ((32'(s_r[4][4:0]) + s_r[8] + 32'h1f) & ~32'h1f))
    else $error("fetch size wrong");
  AST_DTYPE: assert property (done_o && op_r == 3'h2 && s_r[14][3:0] > 4'h9 |-> !ok)
    else $error("reserved type accepted");
  AST_ZERO: assert property (done_o && (op_r == 3'h0 && s_r[8] == 32'h0
    || op_r == 3'h4 && s_r[10] == 32'h0) |-> err_code_o == 4'h1)
    else $error("zero count missed");
  AST_COMPUTE: assert property (done_o && ok && op_r == 3'h3 |-> compute_o == s_r[14][11:8]
    && compute_o inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7})
    else $error("compute type wrong");
  AST_UNMAPPED: assert property (s_rd_far |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_FREEZE: assert property (!clk_en_i |=> $stable(done_o) && $stable(record_addr_o))
    else $error("state moved while frozen");
endmodule

bind desc_field_decode desc_field_decode_chk chk
(
  .ref_clk_i, .srst_i, .clk_en_i, .desc_valid_i, .desc_word_i, .desc_data_i, .desc_last_i,
  .desc_op_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .done_o, .err_code_o, .write_record_o,
  .record_addr_o, .dst_is_src2_o, .fetch_bytes_o, .compute_o
);

`default_nettype wire

// ===== tb/desc_host.sv
// submitter model that hands descriptor words to the decoder
`timescale 1ns/1ps
`default_nettype none

module desc_host
(
  input  wire logic         clk_i,          // bench clock
  input  wire logic         start_i,        // send one descriptor
  input  wire logic [511:0] dsc_i,          // descriptor, word 0 lowest
  output var  logic         valid_o = 1'b0, // word offered
  output var  logic [3:0]   word_o = 4'h0,  // word index
  output var  logic [31:0]  data_o = '0,    // word data
  output var  logic         last_o = 1'b0   // final word
);
  logic [3:0] idx_r = 4'h0; // words sent so far
  logic       run_r = 1'b0; // sending

  // highest word first so order is not assumed; released lines toggle, never hold
  always @(posedge clk_i)
  begin
    if (start_i || run_r)
    begin
      valid_o <= 1'b1;
      word_o  <= ~idx_r;
      data_o  <= dsc_i[{~idx_r, 5'h0} +: 32];
      last_o  <= (idx_r == 4'hf);
      run_r   <= (idx_r != 4'hf);
      idx_r   <= idx_r + 4'h1;
    end
    else
    begin
      valid_o <= 1'b0;
      last_o  <= 1'b0;
      word_o  <= ~word_o;
      data_o  <= ~data_o;
    end
  end
endmodule

`default_nettype wire

// ===== tb/desc_field_decode_bench.sv
// self-checking bench for the descriptor field decoder
`timescale 1ns/1ps
`default_nettype none

module desc_field_decode_bench;
  logic         ref_clk_i = 1'b0; // 20 MHz
  logic         srst_i = 1'b1;    // held 16 cycles
  logic         clk_en_i = 1'b1;  // run enable
  logic         start = 1'b0;     // partner go
  logic [511:0] dsc = '0;         // descriptor image
  logic [2:0]   dop = 3'h0;       // class beside the last word
  logic         sf = 1'b0;        // signed flag
  logic [7:0]   ra = 8'h0;        // register address
  logic [31:0]  wd = '0;          // register write data
  logic         rw = 1'b0;        // write strobe
  logic         rr = 1'b0;        // read strobe
  logic [4:0]   fl = 5'h1c;       // flags: address valid, record, interrupt
  logic         want = 1'b1;      // done expected
  logic [15:0]  ok_ct = 16'h00fa; // legal compute codes
  logic [31:0]  v, v0;            // read results
  int           n_fail = 0;       // mismatches
  int           n_checks = 0;     // comparisons
  logic         dv, dl, done, wrec, s2, ireq, so;
  logic [3:0]   dw, err, it, ot, ct;
  logic [31:0]  dd, rdata, fetch, xfer;
  logic [63:0]  raddr, src, dst;
  logic [15:0]  ih;

  always #25 ref_clk_i = ~ref_clk_i;

  desc_host host
  (
    .clk_i(ref_clk_i), .start_i(start), .dsc_i(dsc), .valid_o(dv), .word_o(dw),
    .data_o(dd), .last_o(dl)
  );

  desc_field_decode dut
  (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i), .desc_valid_i(dv),
    .desc_word_i(dw), .desc_data_i(dd), .desc_last_i(dl), .desc_op_i(dop),
    .signed_flag_i(sf), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(rw), .reg_rd_i(rr),
    .reg_rdata_o(rdata), .done_o(done), .err_code_o(err), .write_record_o(wrec),
    .record_addr_o(raddr), .src_addr_o(src), .dst_addr_o(dst), .dst_is_src2_o(s2),
    .fetch_bytes_o(fetch), .xfer_bytes_o(xfer), .intr_req_o(ireq), .intr_handle_o(ih),
    .in_type_o(it), .out_type_o(ot), .compute_o(ct), .signed_o(so)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge ref_clk_i);
    rw <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    ra <= a;
    rr <= 1'b1;
    @(posedge ref_clk_i);
    rr <= 1'b0;
    #1 d = rdata;
  endtask

  // one descriptor through the partner; record address kept 32-byte aligned
  task automatic go(input logic [2:0] oc, input logic [31:0] sz, input logic [31:0] w10,
                    input logic [15:0] ty, input logic [3:0] ex);
    int k;
    dsc = '0;
    dsc[32 +: 32] = {27'h0, fl};
    dsc[64 +: 64] = 64'h0000_0012_3456_7880;
    dsc[128 +: 64] = 64'h0000_0001_0000_1003;
    dsc[192 +: 64] = 64'h0000_0002_0000_2005;
    dsc[256 +: 32] = sz;
    dsc[288 +: 32] = 32'h0000_00ab;
    dsc[320 +: 32] = w10;
    dsc[448 +: 32] = {16'h0, ty};
    @(posedge ref_clk_i);
    dop <= oc;
    start <= 1'b1;
    @(posedge ref_clk_i);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 40)
    begin
      @(posedge ref_clk_i);
      #1 k++;
    end
    check(done, want);
    if (want)
      check(err, ex);
    if (want && k == 40)
      test_done();
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(8'h00, v);
    check(v, 32'h1);
    rd(8'h04, v);
    check(v, 32'h1000);
    rd(8'h08, v);
    check(v, 32'h20);
    rd(8'h0c, v);
    check(v, 32'h0);
    rd(8'h40, v);
    check(v, 32'h0);
    $display("register test done");
    go(3'h0, 32'h100, 32'h0, 16'h0, 4'h0);
    check(raddr, 64'h0000_0012_3456_7880);
    check(wrec, 1'b1);
    check(src, 64'h0000_0001_0000_1003);
    check(dst, 64'h0000_0002_0000_2005);
    rd(8'h10, v);
    check(v, 32'h2);
    check({fetch, xfer}, {32'h120, 32'h100});
    check({ireq, ih}, 17'h100ab);
    check(s2, 1'b0);
    go(3'h5, 32'h10, 32'h0, 16'h0, 4'h0);
    check(s2, 1'b1);
    fl = 5'h04;
    go(3'h0, 32'h8, 32'h0, 16'h0, 4'h0);
    check({wrec, ireq, ih}, 18'h0);
    go(3'h0, 32'h0, 32'h0, 16'h0, 4'h1);
    check(wrec, 1'b1);
    rd(8'h14, v);
    check(v, 32'h1);
    rd(8'h18, v);
    check(v, 32'h0);
    fl = 5'h08;
    go(3'h0, 32'h0, 32'h0, 16'h0, 4'h1);
    check(wrec, 1'b0);
    check(raddr, 64'h0);
    rd(8'h18, v);
    check(v, 32'h101);
    wr(8'h18, 32'h100);
    rd(8'h18, v);
    check(v, 32'h0);
    fl = 5'h1c;
    $display("address test done");
    go(3'h0, 32'h1000, 32'h0, 16'h0, 4'h0);
    go(3'h0, 32'h1001, 32'h0, 16'h0, 4'h2);
    wr(8'h04, 32'h40);
    go(3'h0, 32'h40, 32'h0, 16'h0, 4'h0);
    go(3'h0, 32'h41, 32'h0, 16'h0, 4'h2);
    wr(8'h04, 32'hffff_ffff);
    go(3'h0, 32'h8000_0001, 32'h0, 16'h0, 4'h2);
    wr(8'h04, 32'h1000);
    go(3'h1, 32'h1, 32'h0, 16'h0, 4'h3);
    go(3'h1, 32'h2, 32'h0, 16'h0, 4'h0);
    go(3'h1, 32'h20, 32'h0, 16'h0, 4'h0);
    go(3'h1, 32'h21, 32'h0, 16'h0, 4'h3);
    go(3'h1, 32'h0, 32'h0, 16'h0, 4'h1);
    go(3'h4, 32'h5, 32'h0, 16'h0, 4'h1);
    go(3'h4, 32'h0, 32'h4, 16'h0, 4'h0);
    go(3'h2, 32'h0, 32'h4, 16'h0, 4'h1);
    go(3'h2, 32'h200, 32'h0, 16'h0033, 4'h0);
    check(xfer, 32'h1000);
    go(3'h2, 32'h201, 32'h0, 16'h0033, 4'h2);
    $display("limit test done");
    for (int t = 0; t < 16; t++)
    begin
      go(3'h2, 32'h1, 32'h0, {8'h0, 4'(t), 4'(t)}, (t > 9) ? 4'h4 : 4'h0);
      if (t < 10)
        check({it, ot}, {4'(t), 4'(t)});
    end
    go(3'h2, 32'h1, 32'h0, 16'h0080, 4'h6);
    go(3'h2, 32'h1, 32'h0, 16'h0086, 4'h6);
    wr(8'h0c, 32'h100);
    go(3'h2, 32'h1, 32'h0, 16'h0086, 4'h0);
    sf <= 1'b1;
    go(3'h2, 32'h1, 32'h0, 16'h0022, 4'h0);
    check(so, 1'b1);
    go(3'h2, 32'h1, 32'h0, 16'h0088, 4'h0);
    check(so, 1'b0);
    sf <= 1'b0;
    for (int c = 0; c < 16; c++)
    begin
      go(3'h3, 32'h1, 32'h0, {4'h0, 4'(c), 8'h22}, ok_ct[c] ? 4'h0 : 4'h5);
      if (ok_ct[c])
        check(ct, 4'(c));
    end
    go(3'h3, 32'h1, 32'h0, 16'h0388, 4'h5);
    go(3'h3, 32'h1, 32'h0, 16'h0788, 4'h0);
    $display("type test done");
    rd(8'h1c, v0);
    wr(8'h00, 32'h0);
    want = 1'b0;
    fl = 5'h08;
    go(3'h0, 32'h0, 32'h0, 16'h0, 4'h1);
    want = 1'b1;
    rd(8'h1c, v);
    check(v, v0);
    rd(8'h18, v);
    check(v, 32'h0);
    wr(8'h00, 32'h1);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    go(3'h0, 32'h0, 32'h0, 16'h0, 4'h1);
    $display("enable test done");
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    check({done, err}, 5'h0);
    rd(8'h0c, v);
    check(v, 32'h0);
    $display("reset test done");
    test_done();
  end
endmodule

`default_nettype wire
